//--- include/tmca_pkg.sv
// shared constants, register map and carrier types of the dual timer block
package tmca_pkg;
	localparam int NUM_TMR     = 2;
	localparam int CNT_W       = 10;
	localparam int CMP_P_W     = 3;
	localparam int P_SHIFT     = CNT_W - CMP_P_W;
	localparam int BYTE_W      = 8;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;
	localparam int INT_W       = 2 * NUM_TMR;
	localparam int TMR_SEL_BIT = 5;
	localparam int IDX_LSB     = 2;
	localparam int IDX_MSB     = 4;

	// per-timer byte registers, timer 1 sits one stride above timer 0, then the shared interrupt status and mask
	localparam logic [ADDR_W-1:0] OFS_C0        = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_C1        = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DL        = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DH        = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_AL        = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_AH        = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TMR1      = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_INT_STAT  = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK  = 8'h44;
	localparam logic [2:0]        IDX_C0        = OFS_C0[IDX_MSB:IDX_LSB];
	localparam logic [2:0]        IDX_C1        = OFS_C1[IDX_MSB:IDX_LSB];
	localparam logic [2:0]        IDX_DL        = OFS_DL[IDX_MSB:IDX_LSB];
	localparam logic [2:0]        IDX_DH        = OFS_DH[IDX_MSB:IDX_LSB];
	localparam logic [2:0]        IDX_AL        = OFS_AL[IDX_MSB:IDX_LSB];
	localparam logic [2:0]        IDX_AH        = OFS_AH[IDX_MSB:IDX_LSB];

	// counter clock select codes
	localparam logic [2:0] CK_SYS4     = 3'h0;
	localparam logic [2:0] CK_SYS      = 3'h1;
	localparam logic [2:0] CK_H16      = 3'h2;
	localparam logic [2:0] CK_H64      = 3'h3;
	localparam logic [2:0] CK_SUB_A    = 3'h4;
	localparam logic [2:0] CK_SUB_B    = 3'h5;
	localparam logic [2:0] CK_EXT_RISE = 3'h6;
	localparam logic [2:0] CK_EXT_FALL = 3'h7;

	// operating modes and pin edge/action codes
	localparam logic [1:0] MODE_CMP    = 2'h0;
	localparam logic [1:0] MODE_CAP    = 2'h1;
	localparam logic [1:0] MODE_PWM    = 2'h2;
	localparam logic [1:0] MODE_TMR    = 2'h3;
	localparam logic [1:0] IO_HOLD     = 2'h0;
	localparam logic [1:0] IO_LOW      = 2'h1;
	localparam logic [1:0] IO_HIGH     = 2'h2;
	localparam logic [1:0] IO_TOGGLE   = 2'h3;
	localparam logic [1:0] CAP_RISE    = 2'h0;
	localparam logic [1:0] CAP_FALL    = 2'h1;
	localparam logic [1:0] CAP_BOTH    = 2'h2;
	localparam logic [1:0] PWM_OFF     = 2'h0;
	localparam logic [1:0] PWM_ON      = 2'h1;
	localparam logic [1:0] PWM_RUN     = 2'h2;
	localparam logic [1:0] PWM_ONESHOT = 2'h3;

	// prescalers
	localparam int         SYS_DIV   = 4;
	localparam int         H_DIV_LO  = 16;
	localparam int         H_DIV_HI  = 64;
	localparam logic [1:0] SYS_LAST  = 2'(SYS_DIV - 1);
	localparam logic [3:0] H_LO_LAST = 4'(H_DIV_LO - 1);
	localparam logic [5:0] H_HI_LAST = 6'(H_DIV_HI - 1);

	// reset values
	localparam logic [BYTE_W-1:0] C0_RST   = 8'h00;
	localparam logic [BYTE_W-1:0] C1_RST   = 8'h00;
	localparam logic [BYTE_W-1:0] BUF_RST  = 8'h00;
	localparam logic [CNT_W-1:0]  COMPARE_A_VALUE_RST = 10'h000;
	localparam logic [INT_W-1:0]  MASK_RST = 4'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic       pau;
		logic [2:0] ck;
		logic       on;
		logic [2:0] rp;
	} tmca_c0_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] io;
		logic       oc;
		logic       pol;
		logic       dpx;
		logic       cclr;
	} tmca_c1_t;

	typedef struct packed {
		logic sys4;
		logic h16;
		logic h64;
		logic sub;
	} tmca_ticks_t;

	typedef struct packed {
		logic a_match;
		logic p_match;
		logic capture;
	} tmca_evt_t;

	typedef struct packed {
		logic       hit;
		logic       tmr_reg;
		logic       tmr;
		logic [2:0] idx;
		logic       stat;
		logic       mask;
	} tmca_dec_t;
endpackage : tmca_pkg

//--- design/tmca_timer_core.sv
// one timer: clock select, 10-bit counter, comparators, capture and output pin
`timescale 1ns/10ps
module tmca_timer_core (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  tmca_pkg::tmca_c0_t          c0,
	input  tmca_pkg::tmca_c1_t          c1,
	input  wire logic [tmca_pkg::CNT_W-1:0] compare_a_value,
	input  tmca_pkg::tmca_ticks_t       ticks,
	input  wire logic                   ext_count_clock_pin,
	input  wire logic                   capture_input_pin,
	output logic [tmca_pkg::CNT_W-1:0]  cnt,
	output tmca_pkg::tmca_evt_t         evt,
	output logic                        pin_level
);
	function automatic logic edge_hit(input logic prev, input logic cur, input logic rise, input logic fall);
		edge_hit = (rise & ~prev & cur) | (fall & prev & ~cur);
	endfunction : edge_hit

	logic                       ext_prev_r;
	logic                       cap_prev_r;
	logic                       on_prev_r;
	logic                       out_r;
	logic                       out_nxt;
	logic [tmca_pkg::CNT_W-1:0] cnt_r;
	logic [tmca_pkg::CNT_W-1:0] cnt_nxt;
	logic                       tick_src;

	wire                        ext_rise  = edge_hit(ext_prev_r, ext_count_clock_pin, 1'b1, 1'b0);
	wire                        ext_fall  = edge_hit(ext_prev_r, ext_count_clock_pin, 1'b0, 1'b1);
	wire                        on_rise   = c0.on & ~on_prev_r;
	wire                        tick_run  = tick_src & c0.on & ~c0.pau;
	wire [tmca_pkg::CNT_W-1:0]  cnt_inc   = tmca_pkg::CNT_W'(cnt_r + 1'b1);
	wire                        a_hit     = tick_run & (cnt_inc == compare_a_value);
	wire                        p_hit     = tick_run & (cnt_inc[tmca_pkg::CNT_W-1:tmca_pkg::P_SHIFT] == c0.rp)
		& (cnt_inc[tmca_pkg::P_SHIFT-1:0] == '0);
	wire                        clr_on_a  = (c1.mode == tmca_pkg::MODE_PWM) ? c1.dpx : c1.cclr;
	wire                        clr_hit   = clr_on_a ? a_hit : p_hit;
	wire                        cap_rise  = (c1.io == tmca_pkg::CAP_RISE) | (c1.io == tmca_pkg::CAP_BOTH);
	wire                        cap_fall  = (c1.io == tmca_pkg::CAP_FALL) | (c1.io == tmca_pkg::CAP_BOTH);
	wire                        cap_hit   = (c1.mode == tmca_pkg::MODE_CAP)
		& edge_hit(cap_prev_r, capture_input_pin, cap_rise, cap_fall); // R7
	wire [tmca_pkg::CNT_W-1:0]  duty      = c1.dpx ? {c0.rp, tmca_pkg::P_SHIFT'(0)} : compare_a_value; // R10

	// clock source mux, internal sources other than sys arrive as enable pulses, sys is a constant enable
	always_comb begin // R4 R16
		case (c0.ck)
			tmca_pkg::CK_SYS4:     tick_src = ticks.sys4;
			tmca_pkg::CK_SYS:      tick_src = 1'b1;
			tmca_pkg::CK_H16:      tick_src = ticks.h16;
			tmca_pkg::CK_H64:      tick_src = ticks.h64;
			tmca_pkg::CK_SUB_A,
			tmca_pkg::CK_SUB_B:    tick_src = ticks.sub;
			tmca_pkg::CK_EXT_RISE: tick_src = ext_rise; // R5
			tmca_pkg::CK_EXT_FALL: tick_src = ext_fall; // R5
			default:               tick_src = 1'b0;
		endcase
	end

	// count up, clear on switch-on or on the selected match, hold when off or paused
	always_comb begin // R3 R15 R17
		if (on_rise) begin
			cnt_nxt = '0;
		end else if (tick_run) begin
			cnt_nxt = clr_hit ? '0 : cnt_inc;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	// output pin behaviour per mode; pwm and compare share the one pin
	always_comb begin // R2 R8 R9
		out_nxt = out_r;
		case (c1.mode)
			tmca_pkg::MODE_CMP: begin
				if (on_rise) begin
					out_nxt = c1.oc;
				end else if (a_hit) begin
					case (c1.io)
						tmca_pkg::IO_LOW:    out_nxt = 1'b0;
						tmca_pkg::IO_HIGH:   out_nxt = 1'b1;
						tmca_pkg::IO_TOGGLE: out_nxt = ~out_r;
						default:             out_nxt = out_r;
					endcase
				end
			end
			tmca_pkg::MODE_PWM: begin
				case (c1.io)
					tmca_pkg::PWM_OFF:  out_nxt = ~c1.oc;
					tmca_pkg::PWM_ON:   out_nxt = c1.oc;
					tmca_pkg::PWM_RUN:  out_nxt = (c0.on && cnt_nxt < duty) ? c1.oc : ~c1.oc; // R10
					tmca_pkg::PWM_ONESHOT: begin
						if (on_rise) begin
							out_nxt = c1.oc;
						end else if (a_hit) begin
							out_nxt = ~c1.oc;
						end
					end
					default: out_nxt = out_r;
				endcase
			end
			default: out_nxt = out_r;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext_prev_r <= 1'b0;
			cap_prev_r <= 1'b0;
			on_prev_r  <= 1'b0;
			out_r      <= 1'b0;
			cnt_r      <= '0;
		end else begin
			ext_prev_r <= ext_count_clock_pin;
			cap_prev_r <= capture_input_pin;
			on_prev_r  <= c0.on;
			out_r      <= out_nxt;
			cnt_r      <= cnt_nxt;
		end
	end

	// in capture mode the capture edge stands in for the comparator A event
	assign evt.a_match = (c1.mode == tmca_pkg::MODE_CAP) ? cap_hit : a_hit; // R6
	assign evt.p_match = p_hit; // R6
	assign evt.capture = cap_hit; // R7
	assign cnt         = cnt_r;
	assign pin_level   = out_r ^ c1.pol;
endmodule : tmca_timer_core

//--- design/tmca_top.sv
// dual timer block with AXI4-Lite register access, byte buffers and interrupts
// Notes on behaviour
// (R1) Two identical timers, each with own counter, comparators, interrupts and pins.
// (R2) Each timer offers counting, capture, compare output, single pulse and PWM.
// (R3) Free-running up-counter; compare match flags event, may clear counter and move pin.
// (R4) Counter clock chosen by three-bit field among internal ratios or external pin.
// (R5) External pin clock counts on rising or falling edge as configured.
// (R6) Separate comparator A and comparator P events; either may clear counter.
// (R7) Capture pin edge selectable: rising, falling, or both.
// (R8) Compare output mode drives pin high, low, or toggles on match.
// (R9) PWM comes out on the same pin as compare output.
// (R10) PWM is edge aligned; software picks whether duty or period is adjustable.
// (R11) Counter and compare A low bytes pass through one shared 8-bit buffer.
// (R12) Compare A low write fills buffer; high write stores high and copies buffer.
// (R13) High byte read returns high and latches low byte; low read returns buffer.
// (R14) Software writes low before high and reads high before low.
// (R15) Counter and compare A are ten bits; comparator P matches top three bits.
// (R16) Clock codes: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// (R17) Switching counter on clears it; switching off freezes its value.
// (R18) Comparator events held as pending flags until software clears them.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module tmca_top (
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire logic [tmca_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [tmca_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [tmca_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [tmca_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          internal_high_clock_tick,
	input  wire logic                          sub_clock_tick,
	input  wire logic [tmca_pkg::NUM_TMR-1:0]  ext_count_clock_pin,
	input  wire logic [tmca_pkg::NUM_TMR-1:0]  capture_input_pin,
	output logic [tmca_pkg::NUM_TMR-1:0]       timer_output_pin,
	output logic                               irq
);
	// split a byte address into the register it names
	function automatic tmca_pkg::tmca_dec_t addr_dec(input logic [tmca_pkg::ADDR_W-1:0] addr);
		logic [2:0] idx;
		logic       in_tmr;
		idx                = addr[tmca_pkg::IDX_MSB:tmca_pkg::IDX_LSB];
		in_tmr             = (addr < tmca_pkg::OFS_INT_STAT) && (idx <= tmca_pkg::IDX_AH)
			&& (addr[tmca_pkg::IDX_LSB-1:0] == '0);
		addr_dec.tmr_reg   = in_tmr;
		addr_dec.tmr       = addr[tmca_pkg::TMR_SEL_BIT];
		addr_dec.idx       = idx;
		addr_dec.stat      = (addr == tmca_pkg::OFS_INT_STAT);
		addr_dec.mask      = (addr == tmca_pkg::OFS_INT_MASK);
		addr_dec.hit       = in_tmr | addr_dec.stat | addr_dec.mask;
	endfunction : addr_dec

	// bus handshake state
	logic                            awready_r;
	logic                            wready_r;
	logic                            bvalid_r;
	logic [1:0]                      bresp_r;
	logic [tmca_pkg::ADDR_W-1:0]     awaddr_r;
	logic [tmca_pkg::BYTE_W-1:0]     wbyte_r;
	logic                            wlane_r;
	logic                            arready_r;
	logic                            ar_pend_r;
	logic [tmca_pkg::ADDR_W-1:0]     araddr_r;
	logic                            rvalid_r;
	logic [1:0]                      rresp_r;
	logic [tmca_pkg::DATA_W-1:0]     rdata_r;
	logic [tmca_pkg::DATA_W-1:0]     rd_word;

	// interrupt, prescaler and pin state
	logic [tmca_pkg::INT_W-1:0]      stat_r;
	logic [tmca_pkg::INT_W-1:0]      stat_nxt;
	logic [tmca_pkg::INT_W-1:0]      mask_r;
	logic [tmca_pkg::INT_W-1:0]      stat_set;
	logic                            irq_r;
	logic [1:0]                      sys_div_r;
	logic [5:0]                      h_div_r;
	logic [tmca_pkg::NUM_TMR-1:0]    pin_r;
	logic [tmca_pkg::NUM_TMR-1:0]    pin_now;
	tmca_pkg::tmca_ticks_t           ticks;
	tmca_pkg::tmca_evt_t             evt_w    [tmca_pkg::NUM_TMR];
	logic [tmca_pkg::BYTE_W-1:0]     tmr_rd   [tmca_pkg::NUM_TMR];

	wire                             aw_take  = s_axi_awvalid & awready_r;
	wire                             w_take   = s_axi_wvalid & wready_r;
	wire                             ar_take  = s_axi_arvalid & arready_r;
	wire                             wr_go    = ~awready_r & ~wready_r & ~bvalid_r;
	wire                             rd_go    = ar_pend_r & ~wr_go & ~rvalid_r;
	wire tmca_pkg::tmca_dec_t        wd       = addr_dec(awaddr_r);
	wire tmca_pkg::tmca_dec_t        rdd      = addr_dec(araddr_r);
	wire                             wr_en    = wr_go & wlane_r & wd.hit;
	wire                             stat_clr = wr_en & wd.stat;
	wire                             mask_wr  = wr_en & wd.mask;

	// write address and data are taken in either order, then executed together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
		end else begin
			awready_r <= aw_take ? 1'b0 : (wr_go ? 1'b1 : awready_r);
			wready_r  <= w_take ? 1'b0 : (wr_go ? 1'b1 : wready_r);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awaddr_r <= '0;
			wbyte_r  <= '0;
			wlane_r  <= 1'b0;
		end else begin
			if (aw_take) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				wbyte_r <= s_axi_wdata[tmca_pkg::BYTE_W-1:0];
				wlane_r <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= tmca_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wd.hit ? tmca_pkg::RESP_OKAY : tmca_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// reads wait one cycle whenever a write executes, so buffer side effects never collide
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arready_r <= 1'b1;
			ar_pend_r <= 1'b0;
			araddr_r  <= '0;
		end else begin
			if (ar_take) begin
				araddr_r <= s_axi_araddr;
			end
			ar_pend_r <= ar_take ? 1'b1 : (rd_go ? 1'b0 : ar_pend_r);
			arready_r <= ar_take ? 1'b0 : ((rvalid_r & s_axi_rready) ? 1'b1 : arready_r);
		end
	end

	always_comb begin
		rd_word = '0;
		if (rdd.tmr_reg) begin
			rd_word = tmca_pkg::DATA_W'(tmr_rd[rdd.tmr]);
		end else if (rdd.stat) begin
			rd_word = tmca_pkg::DATA_W'(stat_r);
		end else if (rdd.mask) begin
			rd_word = tmca_pkg::DATA_W'(mask_r);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rresp_r  <= tmca_pkg::RESP_OKAY;
			rdata_r  <= '0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rdd.hit ? tmca_pkg::RESP_OKAY : tmca_pkg::RESP_DECERR;
			rdata_r  <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// prescalers shared by both timers
	always_ff @(posedge clk_sys or posedge rst) begin // R16
		if (rst) begin
			sys_div_r <= '0;
			h_div_r   <= '0;
		end else begin
			sys_div_r <= 2'(sys_div_r + 1'b1);
			if (internal_high_clock_tick) begin
				h_div_r <= 6'(h_div_r + 1'b1);
			end
		end
	end

	assign ticks.sys4 = (sys_div_r == tmca_pkg::SYS_LAST);
	assign ticks.h16  = internal_high_clock_tick & (h_div_r[3:0] == tmca_pkg::H_LO_LAST);
	assign ticks.h64  = internal_high_clock_tick & (h_div_r == tmca_pkg::H_HI_LAST);
	assign ticks.sub  = sub_clock_tick;

	genvar g;
	generate
		for (g = 0; g < tmca_pkg::NUM_TMR; g++) begin : g_tmr // R1
			tmca_pkg::tmca_c0_t          c0_r;
			tmca_pkg::tmca_c1_t          c1_r;
			logic [tmca_pkg::CNT_W-1:0]  compare_a_value_r;
			logic [tmca_pkg::BYTE_W-1:0] buf_r;
			logic [tmca_pkg::CNT_W-1:0]  cnt_w;

			wire wr_t = wr_en & wd.tmr_reg & (wd.tmr == 1'(g));
			wire rd_t = rd_go & rdd.tmr_reg & (rdd.tmr == 1'(g));

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					c0_r <= tmca_pkg::C0_RST;
					c1_r <= tmca_pkg::C1_RST;
				end else begin
					if (wr_t && wd.idx == tmca_pkg::IDX_C0) begin
						c0_r <= wbyte_r;
					end
					if (wr_t && wd.idx == tmca_pkg::IDX_C1) begin
						c1_r <= wbyte_r;
					end
				end
			end

			// shared low-byte buffer: filled by compare A low write or by high-byte read
			always_ff @(posedge clk_sys or posedge rst) begin // R11
				if (rst) begin
					buf_r <= tmca_pkg::BUF_RST;
				end else if (wr_t && wd.idx == tmca_pkg::IDX_AL) begin
					buf_r <= wbyte_r; // R12
				end else if (rd_t && rdd.idx == tmca_pkg::IDX_DH) begin
					buf_r <= cnt_w[tmca_pkg::BYTE_W-1:0]; // R13
				end else if (rd_t && rdd.idx == tmca_pkg::IDX_AH) begin
					buf_r <= compare_a_value_r[tmca_pkg::BYTE_W-1:0]; // R13
				end
			end

			// high write commits both halves at once; a capture loses to it
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					compare_a_value_r <= tmca_pkg::COMPARE_A_VALUE_RST;
				end else if (wr_t && wd.idx == tmca_pkg::IDX_AH) begin
					compare_a_value_r <= {wbyte_r[tmca_pkg::CNT_W-tmca_pkg::BYTE_W-1:0], buf_r}; // R12 R14
				end else if (evt_w[g].capture) begin
					compare_a_value_r <= cnt_w; // R7
				end
			end

			// low bytes read only the buffer, high bytes read live
			always_comb begin // R11 R13
				case (rdd.idx)
					tmca_pkg::IDX_C0: tmr_rd[g] = c0_r;
					tmca_pkg::IDX_C1: tmr_rd[g] = c1_r;
					tmca_pkg::IDX_DL,
					tmca_pkg::IDX_AL: tmr_rd[g] = buf_r;
					tmca_pkg::IDX_DH: tmr_rd[g] = tmca_pkg::BYTE_W'(cnt_w[tmca_pkg::CNT_W-1:tmca_pkg::BYTE_W]);
					tmca_pkg::IDX_AH: tmr_rd[g] = tmca_pkg::BYTE_W'(compare_a_value_r[tmca_pkg::CNT_W-1:tmca_pkg::BYTE_W]);
					default:          tmr_rd[g] = '0;
				endcase
			end

			tmca_timer_core u_core (
				.clk_sys             (clk_sys),
				.rst                 (rst),
				.c0                  (c0_r),
				.c1                  (c1_r),
				.compare_a_value                (compare_a_value_r),
				.ticks               (ticks),
				.ext_count_clock_pin (ext_count_clock_pin[g]),
				.capture_input_pin   (capture_input_pin[g]),
				.cnt                 (cnt_w),
				.evt                 (evt_w[g]),
				.pin_level           (pin_now[g])
			);

			assign stat_set[2*g]   = evt_w[g].a_match; // R6
			assign stat_set[2*g+1] = evt_w[g].p_match; // R6
		end
	endgenerate

	// sticky flags, write one to clear, a new event beats the clear
	assign stat_nxt = (stat_r & ~(stat_clr ? wbyte_r[tmca_pkg::INT_W-1:0] : '0)) | stat_set; // R18

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stat_r <= '0;
			mask_r <= tmca_pkg::MASK_RST;
			irq_r  <= 1'b0;
			pin_r  <= '0;
		end else begin
			stat_r <= stat_nxt; // R18
			if (mask_wr) begin
				mask_r <= wbyte_r[tmca_pkg::INT_W-1:0];
			end
			irq_r  <= |(stat_r & mask_r);
			pin_r  <= pin_now; // R9
		end
	end

	assign s_axi_awready    = awready_r;
	assign s_axi_wready     = wready_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = arready_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rresp      = rresp_r;
	assign s_axi_rdata      = rdata_r;
	assign timer_output_pin = pin_r;
	assign irq              = irq_r;
endmodule : tmca_top

//--- tb/tmca_pins.sv
// model of the external count clock and capture pins of both timers
`timescale 1ns/10ps
module tmca_pins (
	input  wire logic  clk_sys,
	output logic [1:0] ext_count_clock_pin,
	output logic [1:0] capture_input_pin
);
	initial {ext_count_clock_pin, capture_input_pin} = 4'h0;
	task automatic edges(input int t, input bit cap, input int n, input int gap);
		repeat (n) begin
			@(posedge clk_sys);
			if (cap) capture_input_pin[t] <= ~capture_input_pin[t];
			else ext_count_clock_pin[t] <= ~ext_count_clock_pin[t];
			repeat (gap) @(posedge clk_sys);
		end
	endtask : edges
endmodule : tmca_pins

//--- tb/tmca_checker.sv
// register bus and interrupt assertions of the dual timer block
`timescale 1ns/10ps
module tmca_checker (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("late write reply");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write reply dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
		else $error("late read reply");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read reply dropped");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_ar_busy: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*2])
		else $error("second read taken early");
	a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == tmca_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_fall: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
		else $error("interrupt fell without a write");
endmodule : tmca_checker

//--- tb/test_timer_module_core_access.sv
// self-checking bench of the dual timer block over its register bus
`timescale 1ns/10ps
module test_timer_module_core_access;
	localparam logic [7:0] C0 = tmca_pkg::OFS_C0, C1 = tmca_pkg::OFS_C1, DL = tmca_pkg::OFS_DL, DH = tmca_pkg::OFS_DH;
	localparam logic [7:0] AL = tmca_pkg::OFS_AL, AH = tmca_pkg::OFS_AH, ST = tmca_pkg::OFS_INT_STAT;
	localparam logic [7:0] MK = tmca_pkg::OFS_INT_MASK;
	localparam logic [1:0] OK = tmca_pkg::RESP_OKAY, DE = tmca_pkg::RESP_DECERR;
	logic        clk_sys = 1'b0, rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ext_count_clock_pin, capture_input_pin, timer_output_pin;
	int          err_total = 0, n_tests = 0;
	always #12.5 clk_sys = ~clk_sys;
	tmca_top dut_u (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .internal_high_clock_tick(1'b0), .sub_clock_tick(1'b0),
		.ext_count_clock_pin, .capture_input_pin, .timer_output_pin, .irq);
	tmca_pins pin_u (.clk_sys, .ext_count_clock_pin, .capture_input_pin);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	// one transfer; d is the write or expected read byte
	task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int k = 0;
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		do begin
			@(posedge clk_sys);
			k++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(w ? s_axi_bvalid : s_axi_rvalid) && k < 50);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		chk("resp", w ? s_axi_bresp : s_axi_rresp, er);
		if (!w) chk("rdata", s_axi_rdata, {24'h0, d});
		if (k == 50) begin
			err_total++;
			final_report();
		end
		@(posedge clk_sys);
	endtask : bus
	task automatic w_irq(input logic e);
		int k = 0;
		while (irq !== e && k < 20) begin
			@(posedge clk_sys);
			k++;
		end
		chk("irq", irq, e);
		if (irq !== e) final_report();
	endtask : w_irq
	initial begin
		logic [7:0] b;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		bus(0, C0, 8'h00, OK);
		bus(0, MK, 8'h00, OK);
		bus(0, 8'h80, 8'h00, DE);
		bus(1, 8'h80, 8'h01, DE);
		for (int t = 0; t < 2; t++) begin
			b = 8'(t * 32);
			bus(1, b + AL, 8'h5A + 8'(t), OK);
			bus(1, b + AH, 8'(t + 1), OK);
			bus(1, b + AL, 8'h11, OK);
			bus(0, b + AH, 8'(t + 1), OK);
			bus(0, b + AL, 8'h5A + 8'(t), OK);
		end
		$display("buffer test done");
		bus(1, C0, 8'h68, OK);
		pin_u.edges(0, 0, 8, 2);
		bus(0, DH, 8'h00, OK);
		bus(0, DL, 8'h04, OK);
		bus(1, C1, 8'h40, OK);
		pin_u.edges(0, 1, 1, 2);
		bus(0, AH, 8'h00, OK);
		bus(0, AL, 8'h04, OK);
		pin_u.edges(0, 0, 4, 2);
		pin_u.edges(0, 1, 1, 2);
		bus(0, AH, 8'h00, OK);
		bus(0, AL, 8'h04, OK);
		bus(1, C0, 8'h70, OK);
		pin_u.edges(0, 0, 4, 5);
		bus(0, DH, 8'h00, OK);
		bus(0, DL, 8'h06, OK);
		bus(1, C0, 8'h78, OK);
		pin_u.edges(0, 0, 4, 2);
		bus(0, DH, 8'h00, OK);
		bus(0, DL, 8'h02, OK);
		$display("count and capture test done");
		bus(0, ST, 8'h01, OK);
		bus(1, ST, 8'h0F, OK);
		bus(0, ST, 8'h00, OK);
		bus(1, AL, 8'h03, OK);
		bus(1, AH, 8'h00, OK);
		bus(1, C1, 8'h31, OK);
		bus(1, MK, 8'h01, OK);
		bus(1, C0, 8'h00, OK);
		bus(1, C0, 8'h68, OK);
		pin_u.edges(0, 0, 6, 2);
		w_irq(1'b1);
		chk("pin", timer_output_pin, 2'h1);
		bus(0, DH, 8'h00, OK);
		bus(0, DL, 8'h00, OK);
		bus(0, ST, 8'h01, OK);
		bus(1, ST, 8'h01, OK);
		w_irq(1'b0);
		bus(1, MK, 8'h00, OK);
		pin_u.edges(0, 0, 6, 2);
		bus(0, ST, 8'h01, OK);
		chk("irq", irq, 1'b0);
		chk("pin", timer_output_pin, 2'h0);
		bus(1, C1, 8'hA8, OK);
		pin_u.edges(0, 0, 2, 2);
		chk("pin", timer_output_pin, 2'h1);
		pin_u.edges(0, 0, 4, 2);
		chk("pin", timer_output_pin, 2'h0);
		$display("compare and interrupt test done");
		final_report();
	end
endmodule : test_timer_module_core_access
bind tmca_top tmca_checker chk_u (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .irq);
